// file: common/amx_pkg.sv
// Package for the converter mode, multiplexer and readout control block
// Operation
// (RL1) Accepted test-mode instruction turns eight channel pins into driven outputs.
// (RL2) Test entry with select held low may desynchronise framing; power cycle recovers.
// (RL3) Power cycle (reset) returns device to user mode and resynchronises framing.
// (RL4) Status word bit 9 reports mode: high test, low user; strobed select only.
// (RL5) Host sends recovery instructions only with select strobed around each.
// (RL6) Recovery codes in order: 1xxx1111, 00001110, 00001010, 00001011, 00001111.
// (RL7) Host sends the complete recovery sequence, first and last codes included.
// (RL8) Sign instruction: bits 1-3 low, bits 4-7 1101; bit 0 selects sign.
// (RL9) After user mode, host reissues power-up, sign and acquisition instructions.
// (RL10) Conversion pin high during a sequence shifts held result, starts nothing.
// (RL11) Completed result stays in output register and may be read repeatedly.
// (RL12) After brown-out host drops supply low, rewrites settings and recalibrates.
// (RL13) Multiplexer allows four differential pairs, eight single-ended, or mixtures.
// (RL14) Differential pairs 0-1,2-3,4-5,6-7; even to output a, odd to b.
// (RL15) Single-ended: any channel to output a, common to b; a positive.
// (RL16) Negative input above positive yields negative two's-complement codes.
// (RL17) Single-ended results always carry a zero sign bit.
// (RL18) Signed results are thirteen-bit two's complement, -4096 through +4095.
// (RL19) Any instruction with serial bit 4 low starts a conversion; the code starts none in test mode.
// (RL20) Host confirms mode bit low before resuming conversions after recovery.
package amx_pkg;
    localparam int          INSTR_BITS    = 8;
    localparam int          STATUS_BITS   = 13;
    localparam int          RESULT_BITS   = 13;
    localparam int          CHAN_COUNT    = 8;
    localparam int          MODE_BIT_POS  = 9;
    localparam int          SIGN_BIT_POS  = 0;
    localparam int          CONV_BIT_POS  = 4;
    localparam int          SE_BIT_POS    = 0;
    localparam int          ODD_BIT_POS   = 1;
    localparam int          CHSEL_LSB     = 1;
    // Codes as shift-register images: serial bit 0 lands in bit 0
    localparam logic [7:0]  TEST_MASK     = 8'hf1;
    localparam logic [7:0]  TEST_CODE     = 8'hf1;
    localparam logic [7:0]  RST1_CODE     = 8'h70;
    localparam logic [7:0]  RST2_CODE     = 8'h50;
    localparam logic [7:0]  RST3_CODE     = 8'hd0;
    localparam logic [7:0]  USER_CODE     = 8'hf0;
    localparam logic [7:0]  SIGN_MASK     = 8'hfe;
    localparam logic [7:0]  SIGN_CODE     = 8'hb0;
    localparam logic [7:0]  READ_STATUS   = 8'h30;
    localparam logic [12:0] RESULT_RESET  = 13'h0000;
    localparam logic [12:0] POS_MAX       = 13'h0fff;
    localparam logic [12:0] NEG_MIN       = 13'h1000;

    typedef enum logic [2:0] {
        AMX_SEQ_IDLE,
        AMX_SEQ_R1,
        AMX_SEQ_R2,
        AMX_SEQ_R3,
        AMX_SEQ_R4
    } amx_seq_t;

    typedef struct packed {
        logic [2:0] pair;      // Differential pair or single-ended channel index high bits
        logic       odd;       // Odd channel of pair is positive / odd single-ended channel
        logic       single;    // Single-ended against common
    } amx_chsel_t;

    typedef struct packed {
        logic [CHAN_COUNT-1:0] sel_a;    // Channel routed to output a
        logic [CHAN_COUNT-1:0] sel_b;    // Channel routed to output b
        logic                  com_b;    // Common routed to output b
        logic                  swap;     // Converter input b taken as positive
    } amx_route_t;
endpackage

// file: src/amx_ctrl.sv
// Instruction decode, test/user mode, multiplexer routing and result readout
`timescale 1ns/1ps
module amx_ctrl
    import amx_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // Serial link pins (asynchronous)
    input  wire logic                    sclk,
    input  wire logic                    cs_n,
    input  wire logic                    serial_instruction_in,
    input  wire logic                    conv_n,
    // Conversion core
    input  wire logic                    conv_done,
    input  wire logic [RESULT_BITS-1:0]  conv_result,
    input  wire logic                    status_ready,
    input  wire logic [STATUS_BITS-1:0]  status_core,
    // Outputs
    output logic                         conv_start,
    output logic                         status_load,
    output logic                         result_ready_n,
    output logic [RESULT_BITS-1:0]       out_word,
    output logic                         test_mode,
    output logic                         sign_on,
    output amx_route_t                   route,
    output logic [CHAN_COUNT-1:0]        analog_channel_pins_oe,
    output logic [CHAN_COUNT-1:0]        analog_channel_pins_out
);
    typedef struct packed {
        logic [1:0]             sclk_s;
        logic [1:0]             cs_s;
        logic [1:0]             din_s;
        logic [1:0]             conv_s;
        logic                   sclk_prev;
        logic                   cs_prev;
        logic [INSTR_BITS-1:0]  shreg;
        logic [3:0]             cnt;
        logic                   hold;       // Conversion pin seen high in this sequence
        amx_seq_t               seq;
        logic                   test;
        logic                   sign;
        logic                   start;
        logic                   stload;
        logic                   rdy_n;
        logic [RESULT_BITS-1:0] result;
        logic [RESULT_BITS-1:0] word;
        amx_route_t             rt;
        logic [CHAN_COUNT-1:0]  oe;
        logic [CHAN_COUNT-1:0]  pout;
    } amx_state_t;

    amx_state_t s_q;
    amx_state_t s_d;

    // Only the second synchroniser stages are read by logic
    logic sck;
    logic csn;
    logic din;
    logic cvn;
    logic rise;
    logic ins_done;
    logic [INSTR_BITS-1:0] ins;
    amx_chsel_t ch;
    logic [2:0] idx;

    assign sck  = s_q.sclk_s[1];
    assign csn  = s_q.cs_s[1];
    assign din  = s_q.din_s[1];
    assign cvn  = s_q.conv_s[1];
    assign rise = sck && !s_q.sclk_prev && !csn;

    always_comb begin
        s_d        = s_q;
        s_d.sclk_s = {s_q.sclk_s[0], sclk};
        s_d.cs_s   = {s_q.cs_s[0], cs_n};
        s_d.din_s  = {s_q.din_s[0], serial_instruction_in};
        s_d.conv_s = {s_q.conv_s[0], conv_n};
        s_d.sclk_prev = sck;
        s_d.cs_prev   = csn;
        s_d.start  = 1'b0;
        s_d.stload = 1'b0;
        ins_done   = 1'b0;
        ins        = {din, s_q.shreg[INSTR_BITS-1:1]};
        ch         = '0;
        idx        = '0;

        if (csn && !s_q.cs_prev) begin
            s_d.cnt  = '0;
            s_d.hold = 1'b0;
        end
        // Counting bits from select low; with select held low a stray clock shifts
        // the framing until raising select or reset realigns it (RL2)
        if (rise) begin
            s_d.shreg = ins;
            if (cvn) begin
                s_d.hold = 1'b1;
            end
            if (s_q.cnt == 4'(INSTR_BITS - 1)) begin
                s_d.cnt  = '0;
                ins_done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 4'h1;
            end
        end

        if (ins_done) begin
            s_d.hold = 1'b0;
            if ((ins & TEST_MASK) == TEST_CODE) begin
                s_d.test = 1'b1; // RL1
                s_d.seq  = AMX_SEQ_R1;
            end else if (s_q.test) begin
                // Leaving test mode needs the full sequence in order, with or without select strobed between codes (RL6)
                case (s_q.seq)
                    AMX_SEQ_R1: s_d.seq = (ins == RST1_CODE) ? AMX_SEQ_R2 : AMX_SEQ_IDLE;
                    AMX_SEQ_R2: s_d.seq = (ins == RST2_CODE) ? AMX_SEQ_R3 : AMX_SEQ_IDLE;
                    AMX_SEQ_R3: s_d.seq = (ins == RST3_CODE) ? AMX_SEQ_R4 : AMX_SEQ_IDLE;
                    AMX_SEQ_R4: begin
                        // Besides reset, only the user-mode code after the full chain clears test mode (RL7)
                        s_d.seq = AMX_SEQ_IDLE;
                        if (ins == USER_CODE) begin
                            s_d.test = 1'b0;
                        end
                    end
                    default: s_d.seq = AMX_SEQ_IDLE;
                endcase
            end else if ((ins & SIGN_MASK) == SIGN_CODE) begin
                s_d.sign = ins[SIGN_BIT_POS]; // RL8
            end else if (ins == READ_STATUS) begin
                s_d.stload = 1'b1;
            end else if (!ins[CONV_BIT_POS] && !s_q.hold && !cvn) begin
                // Held conversion pin reads the old result only (RL10)
                s_d.start = 1'b1; // RL19
                ch.single = ins[SE_BIT_POS];
                ch.odd    = ins[ODD_BIT_POS];
                ch.pair   = {1'b0, ins[CHSEL_LSB+2:CHSEL_LSB+1]};
                s_d.rt    = '0;
                if (ch.single) begin
                    idx = {ch.pair[1:0], ch.odd};
                    s_d.rt.sel_a[idx] = 1'b1; // RL15
                    s_d.rt.com_b      = 1'b1; // RL15
                end else begin
                    idx = {ch.pair[1:0], 1'b0};
                    s_d.rt.sel_a[idx]        = 1'b1; // RL14
                    s_d.rt.sel_b[idx + 3'h1] = 1'b1; // RL14
                    s_d.rt.swap = ch.odd; // RL14
                end
            end
        end

        // Each conversion picks its own routing, so pairs and singles mix freely (RL13)
        s_d.oe   = {CHAN_COUNT{s_d.test}}; // RL1
        s_d.pout = s_d.test ? s_q.result[CHAN_COUNT-1:0] : '0;

        if (s_d.start) begin
            s_d.rdy_n = 1'b1;
        end
        if (conv_done) begin
            // Negative differences arrive as two's complement, clipped to range (RL16) (RL18)
            if (s_q.rt.com_b && !s_q.rt.swap) begin
                s_d.result = conv_result[RESULT_BITS-1] ? RESULT_RESET
                                                        : conv_result; // RL17
            end else if (s_q.rt.swap) begin
                s_d.result = (conv_result == NEG_MIN) ? POS_MAX
                                                      : 13'(~conv_result + 13'h1); // RL16
            end else begin
                s_d.result = conv_result; // RL18
            end
            s_d.rdy_n = 1'b0;
        end
        // Result persists until the next conversion overwrites it (RL11)
        if (!s_q.sign && !s_d.result[RESULT_BITS-1]) begin
            s_d.word = s_d.result;
        end else if (!s_q.sign) begin
            s_d.word = RESULT_RESET;
        end else begin
            s_d.word = s_d.result;
        end
        if (status_ready) begin
            s_d.word = status_core;
            s_d.word[MODE_BIT_POS] = s_q.test; // RL4
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q           <= '0;
            s_q.sclk_s    <= 2'h0;
            s_q.cs_s      <= 2'h3;
            s_q.cs_prev   <= 1'b1;
            s_q.conv_s    <= 2'h3;
            s_q.rdy_n     <= 1'b1;
            s_q.sign      <= 1'b1;
            s_q.test      <= 1'b0; // RL3
            s_q.seq       <= AMX_SEQ_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign conv_start              = s_q.start;
    assign status_load             = s_q.stload;
    assign result_ready_n          = s_q.rdy_n;
    assign out_word                = s_q.word;
    assign test_mode               = s_q.test;
    assign sign_on                 = s_q.sign;
    assign route                   = s_q.rt;
    assign analog_channel_pins_oe  = s_q.oe;
    assign analog_channel_pins_out = s_q.pout;
endmodule

// file: tb/amx_host.sv
// Host model driving the serial instruction and conversion pins
`timescale 1ns/1ps
module amx_host (
    // Clock
    input wire logic clk,
    // Pins
    output logic     sclk,
    output logic     cs_n,
    output logic     serial_instruction_in,
    output logic     conv_n
);
    initial begin
        sclk = 0;
        cs_n = 1;
        serial_instruction_in = 0;
        conv_n = 0;
    end
    // Select strobed per byte so a stray edge cannot shift the framing
    task automatic send(input logic [7:0] code, input logic hold);
        @(negedge clk);
        cs_n = 0;
        conv_n = hold;
        for (int i = 0; i < 8; i++) begin
            serial_instruction_in = code[i];
            repeat (4) @(negedge clk);
            sclk = 1;
            repeat (4) @(negedge clk);
            sclk = 0;
        end
        repeat (4) @(negedge clk);
        cs_n = 1;
        serial_instruction_in = ~serial_instruction_in;
        conv_n = 0;
        repeat (8) @(negedge clk);
    endtask
endmodule

// file: tb/amx_monitor.sv
// Concurrent checks on the control block ports
`timescale 1ns/1ps
module amx_monitor
    import amx_pkg::*;
(
    // Clock, reset and pins
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        conv_n,
    input wire logic        conv_done,
    input wire logic        status_ready,
    // Outputs
    input wire logic        conv_start,
    input wire logic        result_ready_n,
    input wire logic [12:0] out_word,
    input wire logic        test_mode,
    input wire logic        sign_on,
    input wire logic [7:0]  analog_channel_pins_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_pins_drive: assert property (test_mode && $past(test_mode) |->
        analog_channel_pins_oe == 8'hff) else $error("pins not driven");
    a_pins_float: assert property (!test_mode && !$past(test_mode) |->
        analog_channel_pins_oe == 8'h00) else $error("pins driven in user mode");
    a_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("start longer than one cycle");
    a_read_only: assert property (conv_n [*8] |-> !conv_start)
        else $error("start with conversion pin high");
    a_busy_start: assert property (conv_start |-> ##[0:1] result_ready_n)
        else $error("ready not cleared by start");
    a_done_ready: assert property (conv_done |-> ##[1:2] !result_ready_n)
        else $error("ready not shown after done");
    a_status_mode: assert property ($past(status_ready) && $past(status_ready, 2) &&
        test_mode == $past(test_mode, 2) |-> out_word[MODE_BIT_POS] == test_mode)
        else $error("mode bit wrong");
    a_word_held: assert property ((!conv_done && !status_ready && $stable(sign_on)) [*3]
        |-> $stable(out_word)) else $error("held word changed");
endmodule
bind amx_ctrl amx_monitor mon (.clk, .rst_n, .conv_n, .conv_done, .status_ready,
    .conv_start, .result_ready_n, .out_word, .test_mode, .sign_on, .analog_channel_pins_oe);

// file: tb/tb_top.sv
// Self-checking bench for the mode, routing and readout control block
`timescale 1ns/1ps
module tb_top;
    import amx_pkg::*;
    logic        clk, rst_n, sclk, cs_n, serial_instruction_in, conv_n;
    logic        conv_done, status_ready, conv_start, status_load;
    logic        result_ready_n, test_mode, sign_on;
    logic [12:0] conv_result, status_core, out_word;
    logic [7:0]  analog_channel_pins_oe, analog_channel_pins_out;
    amx_route_t  route;
    int          error_cnt = 0, tests_run = 0, starts = 0, loads = 0;
    logic [7:0]  recover [5] = '{TEST_CODE, RST1_CODE, RST2_CODE, RST3_CODE, USER_CODE};
    amx_host host (.clk, .sclk, .cs_n, .serial_instruction_in, .conv_n);
    amx_ctrl dut (.clk, .rst_n, .sclk, .cs_n, .serial_instruction_in, .conv_n,
        .conv_done, .conv_result, .status_ready, .status_core, .conv_start, .status_load,
        .result_ready_n, .out_word, .test_mode, .sign_on, .route,
        .analog_channel_pins_oe, .analog_channel_pins_out);
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) starts <= starts + int'(conv_start);
    always @(posedge clk) loads <= loads + int'(status_load);
    task automatic chk(string nm, logic [12:0] exp, logic [12:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic done(logic [12:0] r);
        @(negedge clk);
        conv_result = r;
        conv_done = 1;
        @(negedge clk);
        conv_done = 0;
        repeat (3) @(negedge clk);
    endtask
    task automatic status(logic m);
        int l;
        l = loads;
        status_core = {13{~m}};
        host.send(READ_STATUS, 0);
        if (!m) chk("load", 13'(l + 1), 13'(loads));
        status_ready = 1;
        repeat (3) @(negedge clk);
        chk("mode_bit", 13'(m), 13'(out_word[MODE_BIT_POS]));
        status_ready = 0;
        repeat (3) @(negedge clk);
    endtask
    task automatic t_read;
        host.send(8'h00, 0);
        chk("start", 1, 13'(starts));
        chk("busy", 1, 13'(result_ready_n));
        done(NEG_MIN);
        chk("ready", 0, 13'(result_ready_n));
        host.send(8'h00, 1);
        host.send(8'h00, 1);
        chk("held", NEG_MIN, out_word);
        chk("no_start", 1, 13'(starts));
        host.send(SIGN_CODE, 0);
        chk("sign_off", 0, 13'(sign_on));
        done(POS_MAX);
        chk("unsigned", POS_MAX, out_word);
        host.send(SIGN_CODE | 8'h01, 0);
        chk("sign_on", 1, 13'(sign_on));
        chk("no_start", 1, 13'(starts));
    endtask
    task automatic t_mux;
        for (int p = 0; p < 4; p++) begin
            host.send({4'h0, 2'(p), 2'b00}, 0);
            chk("diff_a", 13'(8'h01 << 2 * p), 13'(route.sel_a));
            chk("diff_b", 13'(9'h004 << 2 * p), 13'({route.sel_b, route.com_b}));
        end
        for (int c = 0; c < 8; c++) begin
            host.send({4'h0, 3'(c), 1'b1}, 0);
            chk("se_a", 13'(8'h01 << c), 13'(route.sel_a));
            chk("se_b", 13'h002, 13'({route.sel_b, route.com_b, route.swap}));
        end
        done(13'h1f00);
        chk("se_sign", 0, out_word);
        host.send(8'h02, 0);
        chk("diff_swap", 13'h001, 13'(route.swap));
        done(13'h0005);
        chk("neg_code", 13'h1ffb, out_word);
    endtask
    task automatic t_test;
        int s;
        host.send(TEST_CODE, 0);
        chk("test", 1, 13'(test_mode));
        chk("pins_oe", 13'h0ff, 13'(analog_channel_pins_oe));
        chk("pins_out", 13'h0fb, 13'(analog_channel_pins_out));
        status(1);
        host.send(RST1_CODE, 0);
        host.send(USER_CODE, 0);
        chk("partial", 1, 13'(test_mode));
        foreach (recover[i]) host.send(recover[i], 0);
        chk("user", 0, 13'(test_mode));
        s = starts;
        host.send(RST2_CODE, 0);
        host.send(SIGN_CODE | 8'h01, 0);
        host.send(RST1_CODE, 0);
        chk("setup", 13'(s), 13'(starts));
        status(0);
        host.send(TEST_CODE, 0);
        @(negedge clk);
        rst_n = 0;
        repeat (2) @(negedge clk);
        rst_n = 1;
        chk("test_rst", 0, 13'(test_mode));
    endtask
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        rst_n = 0;
        conv_done = 0;
        status_ready = 0;
        conv_result = 0;
        status_core = 0;
        repeat (4) @(negedge clk);
        rst_n = 1;
        chk("sign_rst", 1, 13'(sign_on));
        t_read;
        t_mux;
        t_test;
        end_sim;
    end
    // About 2500 cycles expected; a hang stops well past that
    initial begin
        #300_000;
        error_cnt++;
        end_sim;
    end
endmodule
